// File: logic/lcd_ctrl_reset_irq_init.sv
// Segment display controller: configuration registers, frame interrupt and pin drivers.
// Assumes a same-clock register master, a one-cycle frame tick and same-clock low-power levels.
`timescale 1ns/1ps

module lcd_ctrl_reset_irq_init #(
  parameter int NPINS = lcd_ctrl_pkg::NPINS_DEF
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_resetn,
  // Register port
  input  wire logic [6:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr_stb,
  input  wire logic             i_rd_stb,
  output logic      [7:0]       o_rdata,
  // System events
  input  wire logic             i_frame_tick,
  input  wire logic             i_wait_mode,
  input  wire logic             i_stop_mode,
  // Glass drivers
  output logic      [NPINS-1:0] o_seg_out,
  output logic      [NPINS-1:0] o_seg_oe,
  // Bias and clock control
  output logic                  o_charge_pump_en,
  output logic                  o_resistor_bias_en,
  output logic                  o_supply_switch_one,
  output logic                  o_supply_switch_two,
  output logic                  o_ext_top_bias,
  output logic                  o_bias_third,
  output logic                  o_clock_source,
  output logic      [2:0]       o_frame_clock_divider,
  output logic      [2:0]       o_duty_select,
  // Interrupt
  output logic                  o_irq
);

  localparam int NBYTES = (NPINS + 7) / 8;

  if (NPINS < 1 || NPINS > 48) begin : g_npins_check
    $error("NPINS must lie in 1..48");
  end

  lcd_ctrl_pkg::first_ctrl_t  c0_q;
  lcd_ctrl_pkg::second_ctrl_t c1_q;
  lcd_ctrl_pkg::supply_ctrl_t sup_q;
  lcd_ctrl_pkg::blink_ctrl_t  blk_q;

  logic       flag_q;
  logic       flag_d;
  logic       irq_q;
  logic [2:0] phase_q;
  logic [2:0] phase_d;
  logic [7:0] rdata_q;
  logic [3:0] seen_q;

  logic [7:0] pinen_q  [NBYTES];
  logic [7:0] bplane_q [NBYTES];
  logic [7:0] wf_q     [NPINS];

  logic [NPINS-1:0] seg_q;
  logic [NPINS-1:0] oe_q;

  // Address decode
  wire [6:0] pinen_off  = i_addr - lcd_ctrl_pkg::ADR_PINEN;
  wire [6:0] bplane_off = i_addr - lcd_ctrl_pkg::ADR_BPLANE;
  wire [6:0] wf_off     = i_addr - lcd_ctrl_pkg::ADR_WF;
  wire [2:0] pinen_idx  = pinen_off[2:0];
  wire [2:0] bplane_idx = bplane_off[2:0];
  wire [5:0] wf_idx     = wf_off[5:0];

  wire hit_c0     = i_addr == lcd_ctrl_pkg::ADR_CTRL0;
  wire hit_c1     = i_addr == lcd_ctrl_pkg::ADR_CTRL1;
  wire hit_sup    = i_addr == lcd_ctrl_pkg::ADR_SUPPLY;
  wire hit_blk    = i_addr == lcd_ctrl_pkg::ADR_BLINK;
  wire hit_sts    = i_addr == lcd_ctrl_pkg::ADR_STATUS;
  wire hit_clr    = i_addr == lcd_ctrl_pkg::ADR_CLEAR;
  wire hit_pinen  = (i_addr >= lcd_ctrl_pkg::ADR_PINEN) && (pinen_off < 7'(NBYTES));
  wire hit_bplane = (i_addr >= lcd_ctrl_pkg::ADR_BPLANE) && (bplane_off < 7'(NBYTES));
  wire hit_wf     = (i_addr >= lcd_ctrl_pkg::ADR_WF) && (wf_off < 7'(NPINS));

  wire wr_c0     = i_wr_stb && hit_c0;
  wire wr_c1     = i_wr_stb && hit_c1;
  wire wr_sup    = i_wr_stb && hit_sup;
  wire wr_blk    = i_wr_stb && hit_blk;
  wire wr_pinen  = i_wr_stb && hit_pinen;
  wire wr_bplane = i_wr_stb && hit_bplane;
  wire wr_wf     = i_wr_stb && hit_wf;

  // Status and clear registers share the flag position
  wire wr_w1c    = i_wr_stb && (hit_sts || hit_clr);
  wire flag_clr  = wr_w1c && i_wdata[lcd_ctrl_pkg::FLAG_BIT];
  wire [7:0] sts = {flag_q, 7'h00};

  // Read selection
  wire [7:0] rd_mux =
    hit_c0     ? 8'(c0_q)             :
    hit_c1     ? 8'(c1_q)             :
    hit_sup    ? 8'(sup_q)            :
    hit_blk    ? 8'(blk_q)            :
    hit_sts    ? sts                  :
    hit_pinen  ? pinen_q[pinen_idx]   :
    hit_bplane ? bplane_q[bplane_idx] :
    hit_wf     ? wf_q[wf_idx]         :
                 8'h00;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= i_rd_stb ? rd_mux : 8'h00;
    end
  end

  // Control registers
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      c0_q  <= lcd_ctrl_pkg::first_ctrl_t'(lcd_ctrl_pkg::CTRL0_RST);
      c1_q  <= lcd_ctrl_pkg::second_ctrl_t'(lcd_ctrl_pkg::CTRL1_RST);
      sup_q <= lcd_ctrl_pkg::supply_ctrl_t'(lcd_ctrl_pkg::SUPPLY_RST);
      blk_q <= lcd_ctrl_pkg::blink_ctrl_t'(lcd_ctrl_pkg::BLINK_RST);
    end else begin
      if (wr_c0) begin
        c0_q <= lcd_ctrl_pkg::first_ctrl_t'(i_wdata);
      end
      if (wr_c1) begin
        c1_q <= lcd_ctrl_pkg::second_ctrl_t'(i_wdata & lcd_ctrl_pkg::CTRL1_MASK);
      end
      if (wr_sup) begin
        sup_q <= lcd_ctrl_pkg::supply_ctrl_t'(i_wdata & lcd_ctrl_pkg::SUPPLY_MASK);
      end
      if (wr_blk) begin
        blk_q <= lcd_ctrl_pkg::blink_ctrl_t'(i_wdata & lcd_ctrl_pkg::BLINK_MASK);
      end
    end
  end

  // Enable bytes get a defined value so the drivers stay off until software writes them
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int b = 0; b < NBYTES; b++) begin
        pinen_q[b]  <= 8'h00;
        bplane_q[b] <= 8'h00;
      end
    end else begin
      if (wr_pinen) begin
        pinen_q[pinen_idx] <= i_wdata;
      end
      if (wr_bplane) begin
        bplane_q[bplane_idx] <= i_wdata;
      end
    end
  end

  // Waveform store is plain memory with no reset
  always_ff @(posedge i_mclk) begin
    if (wr_wf) begin
      wf_q[wf_idx] <= i_wdata;
    end
  end

  // Frame flag: a tick in the clearing cycle wins
  assign flag_d = i_frame_tick || (flag_q && !flag_clr);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      flag_q <= flag_d;
      irq_q  <= flag_q && c1_q.frame_irq_enable;
    end
  end

  // Backplane phase steps once per frame tick and wraps at the duty code
  assign phase_d = (phase_q >= c0_q.duty_select) ? 3'h0 : phase_q + 3'h1;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_q <= 3'h0;
    end else if (i_frame_tick) begin
      phase_q <= phase_d;
    end
  end

  // Low-power modes only blank the glass when their disable bit is set
  wire low_power_off = (i_wait_mode && c1_q.wait_mode_disable)
                    || (i_stop_mode && c1_q.stop_mode_disable);
  wire drive_ok      = c0_q.display_enable && !low_power_off;
  wire [2:0] fp_phase = blk_q.second_plane_select ? (phase_q ^ lcd_ctrl_pkg::PLANE_XOR) : phase_q;

  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    wire [7:0] wave  = wf_q[p];
    wire       is_bp = bplane_q[p / 8][p % 8];
    wire       pin_en = pinen_q[p / 8][p % 8];
    wire       lvl   = is_bp ? wave[phase_q] : (!blk_q.blank && wave[fp_phase]);

    always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
        seg_q[p] <= 1'b0;
        oe_q[p]  <= 1'b0;
      end else begin
        seg_q[p] <= drive_ok && pin_en && lvl;
        oe_q[p]  <= drive_ok && pin_en;
      end
    end
  end

  // Supply switches: code 11 opens both and expects an external top level
  wire ext_supply = sup_q.supply_select == lcd_ctrl_pkg::VSEL_EXT;

  assign o_supply_switch_one   = sup_q.supply_select == lcd_ctrl_pkg::VSEL_VLL2;
  assign o_supply_switch_two   = sup_q.supply_select == lcd_ctrl_pkg::VSEL_VLL3;
  assign o_ext_top_bias        = ext_supply;
  assign o_charge_pump_en      = sup_q.charge_pump_select;
  assign o_resistor_bias_en    = !sup_q.charge_pump_select;
  assign o_bias_third          = 1'b1;
  assign o_clock_source        = c0_q.clock_source;
  assign o_frame_clock_divider = c0_q.frame_clock_divider;
  assign o_duty_select         = c0_q.duty_select;
  assign o_seg_out             = seg_q;
  assign o_seg_oe              = oe_q;
  assign o_irq                 = irq_q;
  assign o_rdata               = rdata_q;

  // Marks which of the four control registers (CTRL0, CTRL1, SUPPLY, BLINK) software has touched since reset
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      seen_q <= 4'h0;
    end else begin
      seen_q <= seen_q | {wr_blk, wr_sup, wr_c1, wr_c0};
    end
  end

  sequence s_clear_only;
    flag_clr && !i_frame_tick;
  endsequence

  sequence s_pin0_live;
    c0_q.display_enable && pinen_q[0][0];
  endsequence

  sequence s_clear_and_tick;
    flag_clr && i_frame_tick;
  endsequence

  chk_oe_disabled: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !c0_q.display_enable |=> (o_seg_oe == '0))
    else $error("driver enabled while display is off");

  chk_duty_default: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !seen_q[0] |-> (o_duty_select == lcd_ctrl_pkg::CTRL0_RST[2:0]) && o_bias_third)
    else $error("default duty or bias lost");

  chk_reset_fields: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (!seen_q[2] && !seen_q[3]) |->
      (8'(sup_q) == lcd_ctrl_pkg::SUPPLY_RST) && (8'(blk_q) == lcd_ctrl_pkg::BLINK_RST))
    else $error("supply or blink field off its reset value");

  chk_flag_set: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_frame_tick |=> flag_q ##0 sts[lcd_ctrl_pkg::FLAG_BIT])
    else $error("frame tick did not set flag");

  chk_flag_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (flag_q && !flag_clr) |=> flag_q)
    else $error("flag dropped without a clear");

  chk_flag_w1c: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_clear_only |=> !flag_q)
    else $error("write of one did not clear flag");

  chk_zero_write: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (wr_w1c && !i_wdata[lcd_ctrl_pkg::FLAG_BIT] && flag_q) |=> flag_q)
    else $error("write of zero changed flag");

  chk_irq_raise: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (flag_q && c1_q.frame_irq_enable) |=> o_irq)
    else $error("interrupt not raised");

  chk_irq_mask: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !c1_q.frame_irq_enable |=> !o_irq)
    else $error("masked interrupt reached output");

  chk_pump_sel: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    wr_sup |=> (o_charge_pump_en == $past(i_wdata[7])) && (o_resistor_bias_en != o_charge_pump_en))
    else $error("charge pump select not applied");

  chk_ext_supply: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (wr_sup && i_wdata[1:0] == lcd_ctrl_pkg::VSEL_EXT) |=>
      !o_supply_switch_one && !o_supply_switch_two && o_ext_top_bias)
    else $error("supply switch closed with external supply");

  chk_wait_drive: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (s_pin0_live and (i_wait_mode && !c1_q.wait_mode_disable && !i_stop_mode)) |=> o_seg_oe[0])
    else $error("display dropped in wait mode");

  chk_stop_drive: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (s_pin0_live and (i_stop_mode && !c1_q.stop_mode_disable && !i_wait_mode)) |=> o_seg_oe[0])
    else $error("display dropped in stop mode");

  chk_status_read: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (i_rd_stb && hit_sts) |=> (o_rdata[lcd_ctrl_pkg::FLAG_BIT] == $past(flag_q)))
    else $error("status read lost the flag");

  chk_tick_wins: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_clear_and_tick |=> flag_q)
    else $error("clear beat a new frame event");

  chk_irq_drop: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !flag_q |=> !o_irq)
    else $error("interrupt without a flag");

  chk_ext_bias: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_ext_top_bias |-> !o_supply_switch_one && !o_supply_switch_two)
    else $error("internal supply on with external bias");

  chk_resistor_bias: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !o_charge_pump_en |-> o_resistor_bias_en)
    else $error("no bias source with pump off");

endmodule // lcd_ctrl_reset_irq_init

// File: logic/lcd_ctrl_pkg.sv
// Register map, field layouts and reset values of the segment display controller.
// Assumes an 8-bit register port with a 7-bit byte address.
package lcd_ctrl_pkg;

  localparam logic [6:0] ADR_CTRL0  = 7'h00;
  localparam logic [6:0] ADR_CTRL1  = 7'h01;
  localparam logic [6:0] ADR_SUPPLY = 7'h02;
  localparam logic [6:0] ADR_BLINK  = 7'h03;
  localparam logic [6:0] ADR_STATUS = 7'h04;
  localparam logic [6:0] ADR_CLEAR  = 7'h05;
  localparam logic [6:0] ADR_PINEN  = 7'h08;
  localparam logic [6:0] ADR_BPLANE = 7'h10;
  localparam logic [6:0] ADR_WF     = 7'h20;

  localparam int NPINS_DEF = 45;
  localparam int FLAG_BIT  = 7;

  typedef struct packed {
    logic       display_enable;
    logic       clock_source;
    logic [2:0] frame_clock_divider;
    logic [2:0] duty_select;
  } first_ctrl_t;

  typedef struct packed {
    logic       frame_irq_enable;
    logic [4:0] rsvd;
    logic       wait_mode_disable;
    logic       stop_mode_disable;
  } second_ctrl_t;

  typedef struct packed {
    logic       charge_pump_select;
    logic       rsvd_a;
    logic [1:0] pump_clock_adjust;
    logic [1:0] rsvd_b;
    logic [1:0] supply_select;
  } supply_ctrl_t;

  typedef struct packed {
    logic       blink_on;
    logic       second_plane_select;
    logic       blank;
    logic       rsvd;
    logic       blink_style;
    logic [2:0] blink_rate;
  } blink_ctrl_t;

  // Duty code n means n+1 backplane phases; 3 gives one-quarter duty
  localparam logic [7:0] CTRL0_RST   = 8'h03;
  localparam logic [7:0] CTRL1_RST   = 8'h00;
  localparam logic [7:0] SUPPLY_RST  = 8'h03;
  localparam logic [7:0] BLINK_RST   = 8'h00;
  localparam logic [7:0] CTRL1_MASK  = 8'h83;
  localparam logic [7:0] SUPPLY_MASK = 8'hb3;
  localparam logic [7:0] BLINK_MASK  = 8'hef;

  localparam logic [1:0] VSEL_VLL2 = 2'h0;
  localparam logic [1:0] VSEL_VLL3 = 2'h1;
  localparam logic [1:0] VSEL_EXT  = 2'h3;
  localparam logic [2:0] PLANE_XOR = 3'h4;

endpackage

// File: tb/lcd_glass_model.sv
// Behavioural model of the display glass seen from the pin drivers.
// Assumes one enable per pin; a pin that is not driven floats and carries no pull.
`timescale 1ns/1ps

module lcd_glass_model #(
  parameter int NPINS = 45
) (
  // Clock
  input  wire logic             i_mclk,
  // Pin drivers
  input  wire logic [NPINS-1:0] i_seg_out,
  input  wire logic [NPINS-1:0] i_seg_oe,
  // Observed electrode level
  output logic      [NPINS-1:0] o_pin_level
);
  logic [NPINS-1:0] last_q = '0;

  // A floating electrode flips every cycle so a stale level never passes for a driven one
  always @(posedge i_mclk) begin
    last_q <= o_pin_level;
  end

  assign o_pin_level = (i_seg_oe & i_seg_out) | (~i_seg_oe & ~last_q);
endmodule // lcd_glass_model

// File: tb/tb_lcd_ctrl_reset_irq_init.sv
// Self-checking bench for the segment display controller.
// Assumes the register port answers reads one cycle later and the glass model sits on the pins.
`timescale 1ns/1ps

module tb_lcd_ctrl_reset_irq_init;
  logic        i_mclk       = 1'b0;
  logic        i_resetn     = 1'b0;
  logic [6:0]  i_addr       = 7'h00;
  logic [7:0]  i_wdata      = 8'h00;
  logic        i_wr_stb     = 1'b0;
  logic        i_rd_stb     = 1'b0;
  logic        i_frame_tick = 1'b0;
  logic        i_wait_mode  = 1'b0;
  logic        i_stop_mode  = 1'b0;
  logic [7:0]  o_rdata;
  logic [44:0] o_seg_out;
  logic [44:0] o_seg_oe;
  logic [44:0] pin_level;
  logic        o_charge_pump_en;
  logic        o_resistor_bias_en;
  logic        o_supply_switch_one;
  logic        o_supply_switch_two;
  logic        o_ext_top_bias;
  logic        o_bias_third;
  logic        o_clock_source;
  logic [2:0]  o_frame_clock_divider;
  logic [2:0]  o_duty_select;
  logic        o_irq;
  int          n_mismatch   = 0;
  int          checks_done  = 0;

  lcd_ctrl_reset_irq_init #(.NPINS(45)) uut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rdata(o_rdata), .i_frame_tick(i_frame_tick),
    .i_wait_mode(i_wait_mode), .i_stop_mode(i_stop_mode), .o_seg_out(o_seg_out), .o_seg_oe(o_seg_oe),
    .o_charge_pump_en(o_charge_pump_en), .o_resistor_bias_en(o_resistor_bias_en),
    .o_supply_switch_one(o_supply_switch_one), .o_supply_switch_two(o_supply_switch_two),
    .o_ext_top_bias(o_ext_top_bias), .o_bias_third(o_bias_third), .o_clock_source(o_clock_source),
    .o_frame_clock_divider(o_frame_clock_divider), .o_duty_select(o_duty_select), .o_irq(o_irq));

  lcd_glass_model #(.NPINS(45)) glass (.i_mclk(i_mclk), .i_seg_out(o_seg_out), .i_seg_oe(o_seg_oe),
    .o_pin_level(pin_level));

  initial begin
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_mclk) begin i_addr <= a; i_wdata <= d; i_wr_stb <= 1'b1; end
    @(posedge i_mclk) i_wr_stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    @(posedge i_mclk) begin i_addr <= a; i_rd_stb <= 1'b1; end
    @(posedge i_mclk) i_rd_stb <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  task automatic settle;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask

  task automatic tick;
    @(posedge i_mclk) i_frame_tick <= 1'b1;
    @(posedge i_mclk) i_frame_tick <= 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic reset_defaults;
    #1 chk(o_seg_oe, 0);
    chk({o_duty_select, o_bias_third}, {3'h3, 1'b1});
    chk({o_frame_clock_divider, o_charge_pump_en, o_ext_top_bias}, {3'h0, 1'b0, 1'b1});
    // The read register itself is held at zero while reset is low
    rd_chk(lcd_ctrl_pkg::ADR_CTRL0, i_resetn ? lcd_ctrl_pkg::CTRL0_RST : 8'h00);
    rd_chk(lcd_ctrl_pkg::ADR_SUPPLY, i_resetn ? lcd_ctrl_pkg::SUPPLY_RST : 8'h00);
    rd_chk(lcd_ctrl_pkg::ADR_BLINK, i_resetn ? lcd_ctrl_pkg::BLINK_RST : 8'h00);
    rd_chk(7'h7f, 8'h00);
  endtask

  task automatic supply_modes;
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 4; s++) begin
        wr(lcd_ctrl_pkg::ADR_SUPPLY, {p[0], 5'h00, s[1:0]});
        settle();
        chk({o_charge_pump_en, o_resistor_bias_en}, {p[0], ~p[0]});
        chk({o_ext_top_bias, o_supply_switch_one, o_supply_switch_two}, {s == 3, s == 0, s == 1});
      end
    end
  endtask

  task automatic frame_irq;
    wr(lcd_ctrl_pkg::ADR_CTRL1, 8'h00);
    tick();
    settle();
    chk(o_irq, 1'b0);
    rd_chk(lcd_ctrl_pkg::ADR_STATUS, 8'h80);
    wr(lcd_ctrl_pkg::ADR_STATUS, 8'h00);
    rd_chk(lcd_ctrl_pkg::ADR_STATUS, 8'h80);
    wr(lcd_ctrl_pkg::ADR_CTRL1, 8'h80);
    settle();
    chk(o_irq, 1'b1);
    wr(lcd_ctrl_pkg::ADR_CLEAR, 8'h80);
    settle();
    chk(o_irq, 1'b0);
    rd_chk(lcd_ctrl_pkg::ADR_STATUS, 8'h00);
    // Clear and a new event in the same cycle
    @(posedge i_mclk) begin i_addr <= lcd_ctrl_pkg::ADR_CLEAR; i_wdata <= 8'h80; i_wr_stb <= 1'b1; i_frame_tick <= 1'b1; end
    @(posedge i_mclk) begin i_wr_stb <= 1'b0; i_frame_tick <= 1'b0; end
    rd_chk(lcd_ctrl_pkg::ADR_STATUS, 8'h80);
    wr(lcd_ctrl_pkg::ADR_STATUS, 8'h80);
    settle();
    rd_chk(lcd_ctrl_pkg::ADR_STATUS, 8'h00);
    chk(o_irq, 1'b0);
  endtask

  task automatic drive_and_lowpower;
    wr(lcd_ctrl_pkg::ADR_CTRL0, 8'h40);
    wr(lcd_ctrl_pkg::ADR_SUPPLY, 8'h81);
    wr(lcd_ctrl_pkg::ADR_CTRL1, 8'h00);
    wr(lcd_ctrl_pkg::ADR_CTRL0, 8'h6b);
    wr(lcd_ctrl_pkg::ADR_BLINK, 8'h00);
    wr(lcd_ctrl_pkg::ADR_PINEN, 8'hff);
    wr(lcd_ctrl_pkg::ADR_BPLANE, 8'h0f);
    for (int p = 0; p < 45; p++) wr(lcd_ctrl_pkg::ADR_WF + 7'(p), 8'hff);
    wr(lcd_ctrl_pkg::ADR_CTRL0, 8'heb);
    settle();
    chk({o_clock_source, o_frame_clock_divider, o_duty_select}, {1'b1, 3'h5, 3'h3});
    chk(o_seg_oe, 45'hff);
    chk(pin_level[7:0], 8'hff);
    // Blanking drops the frontplanes only; backplanes keep their waveform
    wr(lcd_ctrl_pkg::ADR_BLINK, 8'h20);
    settle();
    chk(pin_level[7:0], 8'h0f);
    wr(lcd_ctrl_pkg::ADR_BLINK, 8'h00);
    @(posedge i_mclk) i_wait_mode <= 1'b1;
    settle();
    chk(o_seg_oe, 45'hff);
    @(posedge i_mclk) begin i_wait_mode <= 1'b0; i_stop_mode <= 1'b1; end
    settle();
    chk(o_seg_oe, 45'hff);
    wr(lcd_ctrl_pkg::ADR_CTRL1, 8'h01);
    settle();
    chk(o_seg_oe, 45'h0);
    @(posedge i_mclk) i_stop_mode <= 1'b0;
    settle();
    chk(o_seg_oe, 45'hff);
    wr(lcd_ctrl_pkg::ADR_CTRL1, 8'h02);
    @(posedge i_mclk) i_wait_mode <= 1'b1;
    settle();
    chk(o_seg_oe, 45'h0);
    @(posedge i_mclk) i_wait_mode <= 1'b0;
    wr(lcd_ctrl_pkg::ADR_CTRL0, 8'h03);
    settle();
    chk(o_seg_oe, 45'h0);
    wr(lcd_ctrl_pkg::ADR_CTRL0, 8'h83);
    settle();
    // Reset in mid-run must float the pins again
    @(posedge i_mclk) i_resetn <= 1'b0;
    @(posedge i_mclk) i_resetn <= 1'b1;
    reset_defaults();
  endtask

  initial begin
    // The in-reset read checks take eight more edges, so reset spans twenty
    repeat (11) @(posedge i_mclk);
    reset_defaults();
    @(posedge i_mclk) i_resetn <= 1'b1;
    reset_defaults();
    supply_modes();
    frame_irq();
    drive_and_lowpower();
    test_done();
  end

  initial begin
    #(4000 * 50);
    n_mismatch++;
    test_done();
  end
endmodule // tb_lcd_ctrl_reset_irq_init
